// ===== hdl/ttw_pkg.sv
package ttw_pkg;
  localparam logic [7:0] SLAVE_RD_ADDR = 8'h89;
  localparam logic [7:0] SA_STATUS = 8'h00;
  localparam logic [7:0] SA_CAP_ODD_A = 8'h67;
  localparam logic [7:0] SA_CAP_ODD_B = 8'h68;
  localparam logic [7:0] SA_CAP_EVE_A = 8'h69;
  localparam logic [7:0] SA_CAP_EVE_B = 8'h6a;
  localparam logic [7:0] SA_ODD_WIN_START = 8'h76;
  localparam logic [7:0] SA_ODD_WIN_END = 8'h77;
  localparam logic [7:0] SA_EVE_WIN_START = 8'h78;
  localparam logic [7:0] SA_EVE_WIN_END = 8'h79;
  localparam logic [7:0] SA_FIRST_ROW = 8'h7a;
  localparam logic [7:0] SA_FINAL_ROW = 8'h7b;
  localparam logic [7:0] SA_MODE_MSBS = 8'h7c;
  localparam logic [7:0] SA_MASK_A = 8'h7e;
  localparam logic [7:0] SA_MASK_B = 8'h7f;
  // shared mode / msb register layout
  localparam int BIT_TTX_STD = 7;
  localparam int BIT_FINAL_MSB = 6;
  localparam int BIT_REQ_PROTO = 5;
  localparam int BIT_FIRST_MSB = 4;
  localparam int BIT_EVE_END_MSB = 3;
  localparam int BIT_ODD_END_MSB = 2;
  localparam int BIT_EVE_START_MSB = 1;
  localparam int BIT_ODD_START_MSB = 0;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] ROW_LOW_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  // status byte layout
  localparam int ST_REV_LSB = 5;
  localparam int ST_ODD_CAP = 4;
  localparam int ST_EVE_CAP = 3;
  localparam int ST_SEQ_FIRST = 1;
  localparam int ST_PARITY = 0;
  // line offsets
  localparam logic [9:0] M_FIRST_OFS = 10'h004;
  localparam logic [9:0] O_FIRST_OFS = 10'h001;
  localparam logic [9:0] M_LAST_OFS = 10'h003;
  localparam logic [9:0] O_LAST_OFS = 10'h000;
  localparam logic [9:0] MASK_FIRST_LINE = 10'h005;
  localparam int MASK_BITS = 16;
  localparam logic [3:0] SEQ_LEN_NTSC = 4'h4;
  localparam logic [3:0] SEQ_LEN_PAL = 4'h8;
  localparam logic [3:0] SEQ_LEN_SECAM = 4'hc;
  localparam logic [7:0] MIN_DATA_DELAY = 8'h02;
  typedef enum logic [1:0] {STD_EURO, STD_NABTS, STD_WST60} ttw_std_t;
  typedef enum logic [1:0] {COL_NTSC, COL_PAL, COL_SECAM} ttw_colour_t;

  function automatic logic [9:0] rowLine(input logic [7:0] low,
                                         input logic msb,
                                         input logic [9:0] ofs);
    rowLine = {1'b0, msb, low} + ofs;
  endfunction
endpackage

// ===== hdl/ttw_req_gen.sv
`timescale 1ns/100ps
`default_nettype none
module ttw_req_gen #(
  parameter int BIT_CYCLES = 4,
  parameter int BITS_EURO = 360,
  parameter int BITS_NABTS = 288,
  parameter int BITS_WST60 = 296
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic lineGo,
  input wire logic protocolOld,
  input wire ttw_pkg::ttw_std_t stdSel,
  output logic reqOut,
  output logic reqRise
);
  import ttw_pkg::*;

  typedef enum logic {RG_IDLE, RG_RUN} ttw_rg_t;
  ttw_rg_t state_r;
  logic [15:0] divCnt_r;
  logic [15:0] bitCnt_r;
  logic [15:0] bitsNeeded;
  logic bitTick;
  logic reqNxt;
  logic req_r;

  always_comb begin
    case (stdSel)
      STD_NABTS: bitsNeeded = 16'(BITS_NABTS);
      STD_WST60: bitsNeeded = 16'(BITS_WST60);
      default: bitsNeeded = 16'(BITS_EURO);
    endcase
  end

  // bit-rate enable from a divider on the core clock
  assign bitTick = (divCnt_r == 16'(BIT_CYCLES - 1));

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= RG_IDLE;
      divCnt_r <= '0;
      bitCnt_r <= '0;
    end else begin
      case (state_r)
        RG_IDLE: begin
          divCnt_r <= '0;
          bitCnt_r <= '0;
          if (lineGo) begin
            state_r <= RG_RUN;
          end
        end
        RG_RUN: begin
          divCnt_r <= bitTick ? '0 : divCnt_r + 16'h0001;
          if (bitTick) begin
            bitCnt_r <= bitCnt_r + 16'h0001;
            if (bitCnt_r == bitsNeeded - 16'h0001) begin
              state_r <= RG_IDLE;
            end
          end
        end
        default: state_r <= RG_IDLE;
      endcase
    end
  end

  // new protocol: high in the first half of each bit slot, one rise per bit
  always_comb begin
    if (state_r != RG_RUN) begin
      reqNxt = 1'b0;
    end else if (protocolOld) begin
      reqNxt = 1'b1;
    end else begin
      reqNxt = (divCnt_r < 16'(BIT_CYCLES / 2 + BIT_CYCLES % 2));
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      req_r <= 1'b0;
    end else begin
      req_r <= reqNxt;
    end
  end

  assign reqOut = req_r;
  assign reqRise = reqNxt & ~req_r;

  old_window_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (state_r == RG_RUN && protocolOld && divCnt_r != '0) |-> reqOut)
    else $error("request dropped inside old protocol window");
  one_rise_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (reqRise && !protocolOld) |=> !reqRise)
    else $error("two request rises without a gap");
endmodule
`default_nettype wire

// ===== hdl/ttw_regs.sv
`timescale 1ns/100ps
`default_nettype none
module ttw_regs #(
  parameter logic [2:0] REVISION_ID = 3'h5, // arbitrary value
  parameter int BIT_CYCLES = 4,
  parameter int BITS_EURO = 360,
  parameter int BITS_NABTS = 288,
  parameter int BITS_WST60 = 296
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic regWrEn,
  input wire logic [7:0] regSubAddr,
  input wire logic [7:0] regWrData,
  input wire logic rdEn,
  input wire logic [7:0] rdSlaveAddr,
  output logic [7:0] rdData,
  output logic rdAck,
  input wire logic fieldFrequencySelect,
  input wire ttw_pkg::ttw_colour_t colourStd,
  input wire logic lineStrobe,
  input wire logic fieldStart,
  input wire logic evenFieldIn,
  input wire logic oddCaptionEncoded,
  input wire logic evenCaptionEncoded,
  input wire logic [7:0] requestToDataDelay,
  input wire logic teletextDataIn,
  output logic teletextRequestOut,
  output logic ttxBit,
  output logic ttxBitValid,
  output logic activeVideo,
  output logic ttxLineActive,
  output ttw_pkg::ttw_std_t ttxStd
);
  import ttw_pkg::*;

  logic [7:0] oddWinStart_r;
  logic [7:0] oddWinEnd_r;
  logic [7:0] eveWinStart_r;
  logic [7:0] eveWinEnd_r;
  logic [7:0] firstRow_r;
  logic [7:0] finalRow_r;
  logic [7:0] modeMsbs_r;
  logic [MASK_BITS-1:0] mask_r;
  logic oddCapDone_r;
  logic eveCapDone_r;
  logic evenField_r;
  logic seqFirst_r;
  logic [3:0] seqCnt_r;
  logic [3:0] seqLen;
  logic [3:0] seqCnt_nxt;
  logic [9:0] lineCnt_r;
  logic lineGoPend_r;
  logic [7:0] rdData_r;
  logic rdAck_r;
  logic [7:0] status;
  logic mSystem;
  logic [9:0] firstLine;
  logic [9:0] lastLine;
  logic [9:0] winStart;
  logic [9:0] winEnd;
  logic inWindow;
  logic maskHit;
  logic [9:0] maskIdx;
  logic reqRise;
  logic [7:0] delayCnt_r;
  logic [7:0] delayLoad;
  logic ttxBit_r;
  logic ttxBitValid_r;
  logic wrOddCap;
  logic wrEveCap;

  function automatic logic wrAt(input logic [7:0] sa);
    wrAt = regWrEn && (regSubAddr == sa);
  endfunction

  // configuration registers, write only over the subaddress port
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      oddWinStart_r <= ROW_LOW_RESET;
      oddWinEnd_r <= ROW_LOW_RESET;
      eveWinStart_r <= ROW_LOW_RESET;
      eveWinEnd_r <= ROW_LOW_RESET;
      firstRow_r <= ROW_LOW_RESET;
      finalRow_r <= ROW_LOW_RESET;
      modeMsbs_r <= MODE_RESET;
      mask_r <= {MASK_RESET, MASK_RESET};
    end else begin
      if (wrAt(SA_ODD_WIN_START)) begin
        oddWinStart_r <= regWrData;
      end
      if (wrAt(SA_ODD_WIN_END)) begin
        oddWinEnd_r <= regWrData;
      end
      if (wrAt(SA_EVE_WIN_START)) begin
        eveWinStart_r <= regWrData;
      end
      if (wrAt(SA_EVE_WIN_END)) begin
        eveWinEnd_r <= regWrData;
      end
      if (wrAt(SA_FIRST_ROW)) begin
        firstRow_r <= regWrData;
      end
      if (wrAt(SA_FINAL_ROW)) begin
        finalRow_r <= regWrData;
      end
      if (wrAt(SA_MODE_MSBS)) begin
        modeMsbs_r <= regWrData;
      end
      if (wrAt(SA_MASK_A)) begin
        mask_r[7:0] <= regWrData;
      end
      if (wrAt(SA_MASK_B)) begin
        mask_r[15:8] <= regWrData;
      end
    end
  end

  // teletext standard decode
  always_comb begin
    if (!fieldFrequencySelect) begin
      ttxStd = STD_EURO;
    end else if (modeMsbs_r[BIT_TTX_STD]) begin
      ttxStd = STD_WST60;
    end else begin
      ttxStd = STD_NABTS;
    end
  end

  // line count restarts on the line carrying the first field sync pulse
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      lineCnt_r <= '0;
    end else if (fieldStart) begin
      lineCnt_r <= '0;
    end else if (lineStrobe) begin
      lineCnt_r <= lineCnt_r + 10'h001;
    end
  end

  // M-systems are the 60 Hz ones
  assign mSystem = fieldFrequencySelect;
  assign firstLine = rowLine(firstRow_r, modeMsbs_r[BIT_FIRST_MSB],
                             mSystem ? M_FIRST_OFS : O_FIRST_OFS);
  assign lastLine = rowLine(finalRow_r, modeMsbs_r[BIT_FINAL_MSB],
                            mSystem ? M_LAST_OFS : O_LAST_OFS);
  assign activeVideo = (lineCnt_r >= firstLine) && (lineCnt_r <= lastLine);

  // per-field teletext window, start and end msbs from the shared register
  always_comb begin
    if (evenField_r) begin
      winStart = rowLine(eveWinStart_r, modeMsbs_r[BIT_EVE_START_MSB],
                         mSystem ? M_FIRST_OFS : O_FIRST_OFS);
      winEnd = rowLine(eveWinEnd_r, modeMsbs_r[BIT_EVE_END_MSB],
                       mSystem ? M_LAST_OFS : O_LAST_OFS);
    end else begin
      winStart = rowLine(oddWinStart_r, modeMsbs_r[BIT_ODD_START_MSB],
                         mSystem ? M_FIRST_OFS : O_FIRST_OFS);
      winEnd = rowLine(oddWinEnd_r, modeMsbs_r[BIT_ODD_END_MSB],
                       mSystem ? M_LAST_OFS : O_LAST_OFS);
    end
  end

  assign inWindow = (lineCnt_r >= winStart) && (lineCnt_r <= winEnd);
  // mask uses the same line number in both field rates; at 60 Hz it is
  // therefore a 625-line numbering applied to 525-line video
  assign maskIdx = lineCnt_r - MASK_FIRST_LINE;
  assign maskHit = (lineCnt_r >= MASK_FIRST_LINE) &&
                   (maskIdx < 10'(MASK_BITS)) && mask_r[maskIdx[3:0]];
  assign ttxLineActive = inWindow && !maskHit;

  // line counter settles one cycle after the strobe, so launch then
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      lineGoPend_r <= 1'b0;
    end else begin
      lineGoPend_r <= lineStrobe && !fieldStart;
    end
  end

  ttw_req_gen #(
    .BIT_CYCLES(BIT_CYCLES),
    .BITS_EURO(BITS_EURO),
    .BITS_NABTS(BITS_NABTS),
    .BITS_WST60(BITS_WST60)
  ) u_req (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .lineGo(lineGoPend_r && ttxLineActive),
    .protocolOld(modeMsbs_r[BIT_REQ_PROTO]),
    .stdSel(ttxStd),
    .reqOut(teletextRequestOut),
    .reqRise(reqRise)
  );

  // data sample point; a rise inside a running delay restarts it
  assign delayLoad = (requestToDataDelay < MIN_DATA_DELAY) ?
                     MIN_DATA_DELAY : requestToDataDelay;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      delayCnt_r <= '0;
      ttxBit_r <= 1'b0;
      ttxBitValid_r <= 1'b0;
    end else begin
      ttxBitValid_r <= 1'b0;
      if (reqRise) begin
        // full load: the count reaches one on the edge before the delay-th edge
        // after the output rises and the bit is taken on the delay-th, never before the source is obliged to be valid
        delayCnt_r <= delayLoad;
      end else if (delayCnt_r != '0) begin
        delayCnt_r <= delayCnt_r - 8'h01;
        if (delayCnt_r == 8'h01) begin
          ttxBit_r <= teletextDataIn;
          ttxBitValid_r <= 1'b1;
        end
      end
    end
  end
  assign ttxBit = ttxBit_r;
  assign ttxBitValid = ttxBitValid_r;

  // caption flags: encoding done wins over a same-cycle host write
  assign wrOddCap = wrAt(SA_CAP_ODD_A) || wrAt(SA_CAP_ODD_B);
  assign wrEveCap = wrAt(SA_CAP_EVE_A) || wrAt(SA_CAP_EVE_B);
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      oddCapDone_r <= 1'b1;
      eveCapDone_r <= 1'b1;
    end else begin
      if (oddCaptionEncoded) begin
        oddCapDone_r <= 1'b1;
      end else if (wrOddCap) begin
        oddCapDone_r <= 1'b0;
      end
      if (evenCaptionEncoded) begin
        eveCapDone_r <= 1'b1;
      end else if (wrEveCap) begin
        eveCapDone_r <= 1'b0;
      end
    end
  end

  // colour field sequence position
  always_comb begin
    case (colourStd)
      COL_PAL: seqLen = SEQ_LEN_PAL;
      COL_SECAM: seqLen = SEQ_LEN_SECAM;
      default: seqLen = SEQ_LEN_NTSC;
    endcase
  end
  assign seqCnt_nxt = (seqCnt_r >= seqLen - 4'h1) ? 4'h0 :
                      seqCnt_r + 4'h1;

  // parity and sequence only move at the boundary so a read is coherent
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      seqCnt_r <= '0;
      seqFirst_r <= 1'b0;
      evenField_r <= 1'b0;
    end else if (fieldStart) begin
      seqCnt_r <= seqCnt_nxt;
      seqFirst_r <= (seqCnt_nxt == 4'h0);
      evenField_r <= evenFieldIn;
    end
  end

  always_comb begin
    status = '0;
    status[7:ST_REV_LSB] = REVISION_ID;
    status[ST_ODD_CAP] = oddCapDone_r;
    status[ST_EVE_CAP] = eveCapDone_r;
    status[ST_SEQ_FIRST] = seqFirst_r;
    status[ST_PARITY] = evenField_r;
  end

  // slave transmitter: answers only its own read address
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdData_r <= '0;
      rdAck_r <= 1'b0;
    end else begin
      rdAck_r <= rdEn && (rdSlaveAddr == SLAVE_RD_ADDR);
      if (rdEn && (rdSlaveAddr == SLAVE_RD_ADDR)) begin
        rdData_r <= status;
      end
    end
  end
  assign rdData = rdData_r;
  assign rdAck = rdAck_r;

  parity_track_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    fieldStart |=> (status[ST_PARITY] == $past(evenFieldIn)))
    else $error("parity bit does not follow field");
  odd_cap_clear_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (wrAt(SA_CAP_ODD_B) && !oddCaptionEncoded) |=> !status[ST_ODD_CAP])
    else $error("odd caption flag not cleared by write");
  odd_cap_set_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    oddCaptionEncoded |=> status[ST_ODD_CAP])
    else $error("odd caption flag not set after encode");
  eve_cap_set_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (evenCaptionEncoded ##1 !wrEveCap) |=> status[ST_EVE_CAP][*1])
    else $error("even caption flag lost");
  status_fixed_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    rdAck |-> (rdData[7:ST_REV_LSB] == REVISION_ID && !rdData[2]))
    else $error("revision or unused status bits wrong");
  read_addr_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (rdEn && rdSlaveAddr != SLAVE_RD_ADDR) |=> !rdAck)
    else $error("status answered at wrong address");
  mask_window_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    ttxLineActive |-> (lineCnt_r >= winStart && lineCnt_r <= winEnd))
    else $error("teletext line outside window");
  wst60_sel_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (ttxStd == STD_WST60) ==
    (modeMsbs_r[BIT_TTX_STD] && fieldFrequencySelect))
    else $error("standard select mismatch");
  last_line_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    activeVideo |-> (lineCnt_r <= {1'b0, modeMsbs_r[BIT_FINAL_MSB], finalRow_r}
                     + (mSystem ? M_LAST_OFS : O_LAST_OFS)))
    else $error("active video beyond last line");
  data_delay_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (reqRise && requestToDataDelay == MIN_DATA_DELAY) ##1 !reqRise
    ##1 !reqRise |=> ttxBitValid)
    else $error("teletext bit not sampled at delay");
endmodule
`default_nettype wire

// ===== sim/ttw_ttx_source.sv
`timescale 1ns/100ps
`default_nettype none
module ttw_ttx_source (
  input wire logic core_clk,
  input wire logic teletextRequestOut,
  input wire logic [7:0] requestToDataDelay,
  output logic teletextDataIn,
  output logic sentBit
);
  int holdCnt;
  logic reqSeen;

  initial begin
    teletextDataIn = 1'b0;
    sentBit = 1'b0;
    holdCnt = 0;
    reqSeen = 1'b0;
  end

  // a rise launched at the previous edge is seen here; the bit stands only
  // over the sampling edge, so an early or late sample reads its inverse
  always @(posedge core_clk) begin
    if (teletextRequestOut === 1'b1 && !reqSeen) begin
      sentBit = 1'($urandom_range(1, 0));
      holdCnt = (requestToDataDelay < 8'h02) ? 1 :
                int'(requestToDataDelay) - 1;
    end else if (holdCnt > 0) begin
      holdCnt = holdCnt - 1;
    end
    reqSeen = (teletextRequestOut === 1'b1);
    teletextDataIn <= (holdCnt == 1) ? sentBit : ~sentBit;
  end
endmodule
`default_nettype wire

// ===== sim/teletext_window_and_status_test.sv
`timescale 1ns/100ps
`default_nettype none
module teletext_window_and_status_test;
  import ttw_pkg::*;
  localparam logic [2:0] REV = 3'h2; // arbitrary value
  localparam int BC = 4;
  localparam int B_EU = 3;
  localparam int B_NA = 4;
  localparam int B_WS = 5;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic regWrEn = 1'b0;
  logic [7:0] regSubAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic rdEn = 1'b0;
  logic [7:0] rdSlaveAddr = 8'h00;
  logic fieldFrequencySelect = 1'b0;
  ttw_colour_t colourStd = COL_NTSC;
  logic lineStrobe = 1'b0;
  logic fieldStart = 1'b0;
  logic evenFieldIn = 1'b0;
  logic oddCaptionEncoded = 1'b0;
  logic evenCaptionEncoded = 1'b0;
  logic [7:0] requestToDataDelay = 8'h02;
  logic [7:0] rdData;
  logic rdAck, teletextDataIn, teletextRequestOut, ttxBit, ttxBitValid;
  logic activeVideo, ttxLineActive, sentBit;
  ttw_std_t ttxStd;
  int failCount = 0;
  int totalChecks = 0;
  int capOdd, capEve, seqCnt, seqBit, seqLen, parity, lineNo, validCnt;
  int ffs, std60, proto, firstC, finalC, oS, oE, eS, eE, mask;
  int ttxChk = 0;

  always #2 core_clk = ~core_clk;

  ttw_regs #(.REVISION_ID(REV), .BIT_CYCLES(BC), .BITS_EURO(B_EU),
    .BITS_NABTS(B_NA), .BITS_WST60(B_WS)) DUT (.core_clk(core_clk),
    .rst_b(rst_b), .regWrEn(regWrEn), .regSubAddr(regSubAddr),
    .regWrData(regWrData), .rdEn(rdEn), .rdSlaveAddr(rdSlaveAddr),
    .rdData(rdData), .rdAck(rdAck),
    .fieldFrequencySelect(fieldFrequencySelect), .colourStd(colourStd),
    .lineStrobe(lineStrobe), .fieldStart(fieldStart),
    .evenFieldIn(evenFieldIn), .oddCaptionEncoded(oddCaptionEncoded),
    .evenCaptionEncoded(evenCaptionEncoded),
    .requestToDataDelay(requestToDataDelay),
    .teletextDataIn(teletextDataIn), .teletextRequestOut(teletextRequestOut),
    .ttxBit(ttxBit), .ttxBitValid(ttxBitValid), .activeVideo(activeVideo),
    .ttxLineActive(ttxLineActive), .ttxStd(ttxStd));

  ttw_ttx_source src (.core_clk(core_clk),
    .teletextRequestOut(teletextRequestOut),
    .requestToDataDelay(requestToDataDelay),
    .teletextDataIn(teletextDataIn), .sentBit(sentBit));

  task automatic stopTest;
    if (failCount == 0 && totalChecks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chkByte(input string what, input logic [7:0] exp,
                         input logic [7:0] got);
    totalChecks++;
    if (got !== exp) begin
      failCount++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chkCount(input string what, input int exp, input int got);
    totalChecks++;
    if (got != exp) begin
      failCount++;
      $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic doReset;
    rst_b = 1'b0;
    repeat (16) @(negedge core_clk);
    rst_b = 1'b1;
    capOdd = 1;
    capEve = 1;
    seqCnt = 0;
    seqBit = 0;
    parity = 0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    regWrEn = 1'b1;
    regSubAddr = a;
    regWrData = d;
    @(negedge core_clk);
    regWrEn = 1'b0;
  endtask

  task automatic rd(input logic [7:0] sa);
    logic [7:0] exp;
    int k;
    exp = {REV, capOdd[0], capEve[0], 1'b0, seqBit[0], parity[0]};
    @(negedge core_clk);
    rdEn = 1'b1;
    rdSlaveAddr = sa;
    @(negedge core_clk);
    rdEn = 1'b0;
    k = 0;
    while (rdAck !== 1'b1 && k < 3) begin
      @(negedge core_clk);
      k++;
    end
    chkByte("rdAck", {7'h00, sa == SLAVE_RD_ADDR}, {7'h00, rdAck});
    if (sa == SLAVE_RD_ADDR) begin
      chkByte("status", exp, rdData);
    end
  endtask

  task automatic field(input logic ev);
    @(negedge core_clk);
    fieldStart = 1'b1;
    evenFieldIn = ev;
    @(negedge core_clk);
    fieldStart = 1'b0;
    lineNo = 0;
    parity = ev;
    seqCnt = (seqCnt + 1) % seqLen;
    seqBit = (seqCnt == 0);
  endtask

  task automatic strobe;
    @(negedge core_clk);
    lineStrobe = 1'b1;
    @(negedge core_clk);
    lineStrobe = 1'b0;
    lineNo++;
  endtask

  function automatic logic inWin(input int l, input int s, input int e);
    return l >= s + (ffs ? 4 : 1) && l <= e + (ffs ? 3 : 0);
  endfunction

  function automatic logic ttxOn(input int l);
    logic hit;
    hit = parity ? inWin(l, eS, eE) : inWin(l, oS, oE);
    return hit && !(l >= 5 && l <= 20 && mask[l - 5]);
  endfunction

  task automatic cfg;
    // set early so the combinational decode has settled before any check
    fieldFrequencySelect = ffs[0];
    wr(SA_ODD_WIN_START, oS[7:0]);
    wr(SA_ODD_WIN_END, oE[7:0]);
    wr(SA_EVE_WIN_START, eS[7:0]);
    wr(SA_EVE_WIN_END, eE[7:0]);
    wr(SA_FIRST_ROW, firstC[7:0]);
    wr(SA_FINAL_ROW, finalC[7:0]);
    wr(SA_MODE_MSBS, {std60[0], finalC[8], proto[0], firstC[8], eE[8], oE[8],
       eS[8], oS[8]});
    wr(SA_MASK_A, mask[7:0]);
    wr(SA_MASK_B, mask[15:8]);
  endtask

  task automatic sweep;
    for (int l = 0; l <= 305; l++) begin
      if (l > 0) strobe;
      chkByte("activeVideo", {7'h00, inWin(lineNo, firstC, finalC)},
              {7'h00, activeVideo});
      chkByte("ttxLineActive", {7'h00, ttxOn(lineNo)},
              {7'h00, ttxLineActive});
    end
  endtask

  task automatic ttxLine;
    int rises;
    int highs;
    int bits;
    logic prev;
    bits = std60 ? B_WS : (ffs ? B_NA : B_EU);
    strobe;
    rises = 0;
    highs = 0;
    prev = 1'b0;
    validCnt = 0;
    repeat (40) begin
      @(negedge core_clk);
      rises += (teletextRequestOut === 1'b1 && !prev);
      highs += (teletextRequestOut === 1'b1);
      prev = (teletextRequestOut === 1'b1);
    end
    if (!ttxOn(lineNo)) bits = 0;
    chkCount("request rises", proto ? (bits > 0) : bits, rises);
    chkCount("request high", bits * (proto ? BC : (BC + 1) / 2), highs);
    chkCount("bit samples", proto ? (bits > 0) : bits, validCnt);
  endtask

  always @(negedge core_clk) begin
    if (ttxChk != 0 && ttxBitValid === 1'b1) begin
      validCnt++;
      chkByte("ttxBit", {7'h00, sentBit}, {7'h00, ttxBit});
    end
  end

  initial begin
    #100000;
    failCount++;
    stopTest;
  end

  initial begin
    void'($urandom(82244));
    seqLen = 4;
    doReset;
    rd(SLAVE_RD_ADDR);
    repeat (4) rd(8'h8a + 8'($urandom_range(100, 0)));
    for (int i = 0; i < 4; i++) begin
      wr(SA_CAP_ODD_A + 8'(i), 8'($urandom));
      if (i < 2) capOdd = 0;
      else capEve = 0;
      rd(SLAVE_RD_ADDR);
      @(negedge core_clk);
      oddCaptionEncoded = (i < 2);
      evenCaptionEncoded = (i >= 2);
      @(negedge core_clk);
      oddCaptionEncoded = 1'b0;
      evenCaptionEncoded = 1'b0;
      capOdd = 1;
      capEve = 1;
      rd(SLAVE_RD_ADDR);
    end
    for (int c = 0; c < 3; c++) begin
      colourStd = ttw_colour_t'(c);
      seqLen = 4 * (c + 1);
      doReset;
      for (int f = 0; f <= 2 * seqLen; f++) begin
        field(1'($urandom_range(1, 0)));
        rd(SLAVE_RD_ADDR);
      end
    end
    for (int c = 0; c < 4; c++) begin
      ffs = c % 2;
      std60 = 0;
      proto = 0;
      firstC = $urandom_range(150, 0);
      finalC = firstC + $urandom_range(150, 0);
      oS = $urandom_range(6, 0);
      oE = $urandom_range(300, 12);
      eS = $urandom_range(270, 0);
      eE = $urandom_range(300, 12);
      mask = ffs ? 0 : $urandom_range(16'hffff, 0);
      cfg;
      field(1'b0);
      sweep;
      field(1'b1);
      sweep;
    end
    for (int c = 0; c < 6; c++) begin
      ffs = (c % 3) > 0;
      std60 = (c % 3) == 2;
      proto = c / 3;
      oS = 3;
      oE = 5;
      mask = ffs ? 0 : 1;
      requestToDataDelay = 8'(2 + c % 2);
      cfg;
      chkByte("ttxStd", {6'h00, std60 ? STD_WST60 : (ffs ? STD_NABTS : STD_EURO)},
              {6'h00, ttxStd});
      field(1'b0);
      ttxChk = 1;
      for (int l = 1; l < 10; l++) ttxLine;
      ttxChk = 0;
    end
    stopTest;
  end
endmodule
`default_nettype wire
